//--- design/asro_fifo.sv
`timescale 1ns/100ps

module asro_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
)
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        in_ready;
        logic                        out_valid;
    } asro_fifo_state_t;

    asro_fifo_state_t q;
    asro_fifo_state_t d;
    logic             wr;
    logic             rd;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Flags are registered from the next count, so they stay honest
    // without a combinational path to the ports.
    always_comb
    begin
        d  = q;
        wr = in_valid && q.in_ready;
        rd = out_ready && q.out_valid;
        if (wr)
        begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr        = q.wr_ptr + 1'b1;
        end
        if (rd)
        begin
            d.rd_ptr = q.rd_ptr + 1'b1;
        end
        if (wr && !rd)
        begin
            d.count = q.count + 1'b1;
        end
        else if (rd && !wr)
        begin
            d.count = q.count - 1'b1;
        end
        d.in_ready  = d.count != CW'(DEPTH);
        d.out_valid = d.count != '0;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            q           <= '0;
            q.in_ready  <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign in_ready  = q.in_ready;
    assign out_valid = q.out_valid;
    assign out_data  = q.mem[q.rd_ptr];

endmodule

//--- design/asro_pkg.sv
package asro_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;

    // ------------------------------------------------------------
    // Result and slot layout
    // ------------------------------------------------------------
    localparam int RESULT_W   = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int RISE_W     = 7;
    localparam int BIT_W      = 4;
    localparam int SLOT_W     = 3;
    localparam int SEL_W      = 3;

    // Rising serial clock edges from the trigger to the first data bit
    localparam logic [RISE_W-1:0] LEAD_LAST_RISE = 7'h02;
    // Rising serial clock edges during which further triggers are ignored
    localparam logic [RISE_W-1:0] LOCKOUT_RISES  = 7'h60;

    // Bit positions inside a 16-clock slot
    localparam logic [BIT_W-1:0]  SLOT_LAST_BIT  = 4'hF;
    localparam logic [BIT_W-1:0]  DONTCARE_FIRST = 4'hC;
    localparam logic [BIT_W-1:0]  HIZ_FIRST      = 4'hE;

    localparam logic [SLOT_W-1:0] MAX_SLOTS      = 3'h6;
    localparam logic [SLOT_W-1:0] FIRST_SLOT     = 3'h0;
    localparam logic [SLOT_W-1:0] ONE_SLOT       = 3'h1;
    localparam logic [SEL_W-1:0]  SEL_NONE       = 3'h0;

    // Level driven during the two don't-care bit periods
    localparam logic              DONTCARE_LEVEL = 1'h0;

    localparam logic [RESULT_W-1:0] RESULT_ZERO  = 12'h000;

endpackage

//--- design/asro_serial_out.sv
`timescale 1ns/100ps

// Function
// R1 - Serial data output is high-impedance right after reset, no command needed.
// R2 - Output stays high-impedance until a trigger rising edge starts a conversion.
// R3 - Third serial clock rise after the trigger launches up to six 12-bit results.
// R4 - Each result is followed by two don't-care bits then two high-impedance clocks.
// R5 - Every bit is valid before the next serial clock rise after its launch.
// R6 - A frame carries 16 to 96 bits, one 16-bit slot per channel.
// R7 - Host takes an external positive frame sync and external positive-edge clock.
// R8 - Each result is sent most significant bit first.
// R9 - Triggers are ignored until 96 serial clock rises follow an accepted trigger.
// R10 - Host supplies 16 serial clocks per selected channel.
// R11 - Host captures output bits on the falling serial clock edge.
// R12 - Slot count follows the select inputs; results go out in ascending channel order.
module asro_serial_out
    import asro_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RST_B,
    input  wire logic                SERIAL_CLOCK,
    input  wire logic                CONVERSION_TRIGGER,
    input  wire logic                CHANNEL_COUNT_SELECT_BIT0,
    input  wire logic                CHANNEL_COUNT_SELECT_BIT1,
    input  wire logic                CHANNEL_COUNT_SELECT_BIT2,
    input  wire logic [RESULT_W-1:0] RESULT_DATA,
    input  wire logic                RESULT_VALID,
    output logic                     RESULT_READY,
    output logic                     SERIAL_DATA_OUT,
    output logic                     SERIAL_DATA_OE_B,
    output logic                     UNDERRUN,
    output logic                     BUSY
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASRO_IDLE,
        ASRO_LEAD,
        ASRO_SHIFT
    } asro_phase_t;

    typedef struct packed {
        logic                sck_s1;
        logic                sck_s2;
        logic                sck_s3;
        logic                conversion_trigger_s1;
        logic                conversion_trigger_s2;
        logic                conversion_trigger_s3;
        logic [SEL_W-1:0]    sel_s1;
        logic [SEL_W-1:0]    sel_s2;
        asro_phase_t         phase;
        logic [RISE_W-1:0]   rise_cnt;
        logic [BIT_W-1:0]    bit_cnt;
        logic [SLOT_W-1:0]   slot_cnt;
        logic [SLOT_W-1:0]   slots;
        logic [RESULT_W-1:0] shreg;
        logic                sdo;
        logic                sdo_oe_b;
        logic                pop;
        logic                underrun;
        logic                busy;
    } asro_state_t;

    // ------------------------------------------------------------
    // Reset value
    // ------------------------------------------------------------
    // The rise counter rests at the lockout limit so that the very
    // first trigger after reset is accepted.
    localparam asro_state_t RESET_STATE = '{
        sck_s1   : 1'h0,
        sck_s2   : 1'h0,
        sck_s3   : 1'h0,
        conversion_trigger_s1  : 1'h0,
        conversion_trigger_s2  : 1'h0,
        conversion_trigger_s3  : 1'h0,
        sel_s1   : SEL_NONE,
        sel_s2   : SEL_NONE,
        phase    : ASRO_IDLE,
        rise_cnt : LOCKOUT_RISES,
        bit_cnt  : SLOT_LAST_BIT,
        slot_cnt : FIRST_SLOT,
        slots    : MAX_SLOTS,
        shreg    : RESULT_ZERO,
        sdo      : 1'h0,
        sdo_oe_b : 1'h1,
        pop      : 1'h0,
        underrun : 1'h0,
        busy     : 1'h0
    };

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    asro_state_t         q;
    asro_state_t         d;
    logic                sck_rise;
    logic                conversion_trigger_rise;
    logic                launch;
    logic [BIT_W-1:0]    next_bit;
    logic [RESULT_W-1:0] fifo_data;
    logic                fifo_valid;
    logic                fifo_in_ready;

    // ------------------------------------------------------------
    // Channel-count decode
    // ------------------------------------------------------------
    // Codes outside one to six fall back to a full frame rather than
    // an empty one, so a floating select never silences the link.
    function automatic logic [SLOT_W-1:0] slots_from_select(input logic [SEL_W-1:0] sel);
        logic [SLOT_W-1:0] n;
        n = MAX_SLOTS;
        if (sel != SEL_NONE && sel <= MAX_SLOTS)
        begin
            n = sel;
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // Lockout and edge decode
    // ------------------------------------------------------------
    // Shared by the rise counter, trigger acceptance and BUSY, so all
    // three agree on the cycle in which the lockout ends.
    function automatic logic lockout_over(input logic [RISE_W-1:0] rises);
        return rises == LOCKOUT_RISES;
    endfunction

    // Synchronised level that is high now and was low one cycle ago
    function automatic logic rose_now(input logic now_lvl, input logic was_lvl);
        return now_lvl && !was_lvl;
    endfunction

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    // The serial link cannot stall, so the producer is the side that
    // sees back-pressure through RESULT_READY.
    asro_fifo
    #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk       (CLK),
        .rst_b     (RST_B),
        .in_data   (RESULT_DATA),
        .in_valid  (RESULT_VALID),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (q.pop)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d          = q;
        launch     = 1'b0;
        next_bit   = q.bit_cnt + 1'b1;

        // Pin synchronisers; edges are decoded from the second and third stages, the first only feeds the second
        d.sck_s1   = SERIAL_CLOCK;
        d.sck_s2   = q.sck_s1;
        d.sck_s3   = q.sck_s2;
        d.conversion_trigger_s1  = CONVERSION_TRIGGER;
        d.conversion_trigger_s2  = q.conversion_trigger_s1;
        d.conversion_trigger_s3  = q.conversion_trigger_s2;
        d.sel_s1   = {CHANNEL_COUNT_SELECT_BIT2, CHANNEL_COUNT_SELECT_BIT1, CHANNEL_COUNT_SELECT_BIT0};
        d.sel_s2   = q.sel_s1;

        sck_rise   = rose_now(q.sck_s2, q.sck_s3);
        conversion_trigger_rise  = rose_now(q.conversion_trigger_s2, q.conversion_trigger_s3);

        d.pop      = 1'b0;
        d.underrun = 1'b0;

        // Saturating count of serial clock rises since the trigger
        if (sck_rise && !lockout_over(q.rise_cnt))
        begin
            d.rise_cnt = q.rise_cnt + 1'b1; // R9
        end

        unique case (q.phase)
            ASRO_IDLE:
            begin
                d.sdo_oe_b = 1'b1; // R2
            end
            ASRO_LEAD:
            begin
                // The third rise after the trigger carries the first MSB
                if (sck_rise && q.rise_cnt == LEAD_LAST_RISE)
                begin
                    launch     = 1'b1; // R3
                    d.slot_cnt = FIRST_SLOT;
                end
            end
            ASRO_SHIFT:
            begin
                if (sck_rise)
                begin
                    if (q.bit_cnt == SLOT_LAST_BIT)
                    begin
                        if (q.slot_cnt == q.slots - ONE_SLOT)
                        begin
                            d.phase    = ASRO_IDLE; // R6
                            d.sdo_oe_b = 1'b1;
                        end
                        else
                        begin
                            launch     = 1'b1;
                            d.slot_cnt = q.slot_cnt + ONE_SLOT; // R12
                        end
                    end
                    else
                    begin
                        d.bit_cnt = next_bit;
                        if (next_bit < DONTCARE_FIRST)
                        begin
                            d.sdo   = q.shreg[RESULT_W-1]; // R8
                            d.shreg = {q.shreg[RESULT_W-2:0], 1'b0};
                        end
                        else if (next_bit < HIZ_FIRST)
                        begin
                            d.sdo      = DONTCARE_LEVEL; // R4
                            d.sdo_oe_b = 1'b0;
                        end
                        else
                        begin
                            d.sdo_oe_b = 1'b1; // R4
                        end
                    end
                end
            end
            // The fourth phase code is never entered; should it appear,
            // fall back to idle with the pin released.
            default:
            begin
                d.phase    = ASRO_IDLE;
                d.sdo_oe_b = 1'h1;
            end
        endcase

        // Start of a slot: the oldest buffered result goes out first,
        // so results leave in the order they were written.
        if (launch)
        begin
            d.phase    = ASRO_SHIFT;
            d.bit_cnt  = '0;
            d.sdo_oe_b = 1'b0;
            if (fifo_valid)
            begin
                d.sdo   = fifo_data[RESULT_W-1]; // R8
                d.shreg = {fifo_data[RESULT_W-2:0], 1'b0};
                d.pop   = 1'b1; // R12
            end
            else
            begin
                // Nothing to send: zeros go out and the slip is flagged
                d.sdo      = 1'b0;
                d.shreg    = RESULT_ZERO;
                d.underrun = 1'b1;
            end
        end

        // A trigger is taken only once the lockout has run out; it may
        // cut the last don't-care bit and the trailing high-impedance bits of a previous six-slot frame.
        if (conversion_trigger_rise && lockout_over(q.rise_cnt))
        begin
            d.rise_cnt = '0; // R9
            d.phase    = ASRO_LEAD; // R2
            d.slots    = slots_from_select(q.sel_s2); // R12
            d.sdo_oe_b = 1'b1;
        end

        d.busy = !lockout_over(d.rise_cnt);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Each bit is set two clock cycles after the pin edge reaches the
    // synchroniser, well inside one serial clock period at supported rates.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            q <= RESET_STATE; // R1
        end
        else
        begin
            q <= d; // R5
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SERIAL_DATA_OUT  = q.sdo;
    assign SERIAL_DATA_OE_B = q.sdo_oe_b;
    assign UNDERRUN         = q.underrun;
    assign BUSY             = q.busy;
    assign RESULT_READY     = fifo_in_ready;

endmodule

//--- tb/asro_host.sv
`timescale 1ns/100ps

module asro_host
(
    input  wire logic CLK,
    input  wire logic SDO,
    input  wire logic SDO_OE_B,
    output logic      SCK,
    output logic      FSYNC
);
    logic       last_q = 1'b0;
    logic       line;
    logic [1:0] cap [0:99];

    // Released line shows the inverse of its last level, so a stale bit never passes
    assign line = SDO_OE_B ? ~last_q : SDO;
    always @(posedge CLK)
    begin
        if (!SDO_OE_B)
            last_q <= SDO;
    end

    initial
    begin
        SCK   = 1'b0;
        FSYNC = 1'b0;
    end

    // Clock stands still between frames; sync pulse doubles as trigger
    task automatic frame(input int n, input int retrig, input bit trig);
        @(posedge CLK);
        FSYNC <= trig;
        repeat (6) @(posedge CLK);
        for (int r = 1; r <= n; r++)
        begin
            SCK <= 1'b1;
            if (r == 2 || r == retrig + 2)
                FSYNC <= 1'b0;
            else if (r == retrig)
                FSYNC <= 1'b1;
            repeat (5) @(posedge CLK);
            SCK      <= 1'b0;
            cap[r-1] = {SDO_OE_B, line};
            repeat (5) @(posedge CLK);
        end
    endtask
endmodule

//--- tb/asro_serial_out_chk.sv
`timescale 1ns/100ps

module asro_serial_out_chk
    import asro_pkg::*;
(
    input wire logic                CLK,
    input wire logic                RST_B,
    input wire logic                SERIAL_CLOCK,
    input wire logic                CONVERSION_TRIGGER,
    input wire logic                CHANNEL_COUNT_SELECT_BIT0,
    input wire logic                CHANNEL_COUNT_SELECT_BIT1,
    input wire logic                CHANNEL_COUNT_SELECT_BIT2,
    input wire logic [RESULT_W-1:0] RESULT_DATA,
    input wire logic                RESULT_VALID,
    input wire logic                RESULT_READY,
    input wire logic                SERIAL_DATA_OUT,
    input wire logic                SERIAL_DATA_OE_B,
    input wire logic                UNDERRUN,
    input wire logic                BUSY
);
    logic       sck_q;
    logic       rise;
    logic [4:0] drive_q;
    logic [6:0] busy_q;

    // ------------------------------------------------------------
    // Serial clock rises counted per drive stretch and per lockout
    // ------------------------------------------------------------
    assign rise = SERIAL_CLOCK & ~sck_q;
    always_ff @(posedge CLK)
    begin
        sck_q   <= SERIAL_CLOCK;
        drive_q <= (!RST_B || SERIAL_DATA_OE_B) ? 5'h00 : drive_q + 5'(rise);
        busy_q  <= (!RST_B || !BUSY) ? 7'h00 : busy_q + 7'(rise);
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    property p_rst_idle; $rose(RST_B) |-> SERIAL_DATA_OE_B && !BUSY && !UNDERRUN; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    property p_drv_busy; $fell(SERIAL_DATA_OE_B) |-> BUSY; endproperty
    a_drv_busy: assert property (p_drv_busy) else $error("drive without conversion");
    property p_busy_cause; $rose(BUSY) |-> $past(CONVERSION_TRIGGER, 3); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
    property p_first_bit; $fell(SERIAL_DATA_OE_B) && busy_q < 7'h10 |-> busy_q == 7'h03; endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit not on third rise");
    property p_drv_len; $rose(SERIAL_DATA_OE_B) |-> drive_q == 5'h0E; endproperty
    a_drv_len: assert property (p_drv_len) else $error("drive stretch not 14 bits");
    property p_timing;
        $changed({SERIAL_DATA_OE_B, SERIAL_DATA_OUT}) |-> $past(rise, 2) || $past(rise, 3) || $past(rise, 4);
    endproperty
    a_timing: assert property (p_timing) else $error("output moved without clock rise");
    property p_lock; $fell(BUSY) |-> busy_q == 7'h60; endproperty
    a_lock: assert property (p_lock) else $error("lockout length wrong");
    property p_under; UNDERRUN |-> !SERIAL_DATA_OE_B && !SERIAL_DATA_OUT ##1 !UNDERRUN; endproperty
    a_under: assert property (p_under) else $error("underrun slot not zero");

    c_under: cover property ($rose(UNDERRUN));
    c_lock: cover property ($fell(BUSY));
    c_drive: cover property ($fell(SERIAL_DATA_OE_B));
endmodule

bind asro_serial_out asro_serial_out_chk chk_i
(
    .CLK(CLK), .RST_B(RST_B), .SERIAL_CLOCK(SERIAL_CLOCK), .CONVERSION_TRIGGER(CONVERSION_TRIGGER),
    .CHANNEL_COUNT_SELECT_BIT0(CHANNEL_COUNT_SELECT_BIT0), .CHANNEL_COUNT_SELECT_BIT1(CHANNEL_COUNT_SELECT_BIT1),
    .CHANNEL_COUNT_SELECT_BIT2(CHANNEL_COUNT_SELECT_BIT2), .RESULT_DATA(RESULT_DATA),
    .RESULT_VALID(RESULT_VALID), .RESULT_READY(RESULT_READY), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
    .SERIAL_DATA_OE_B(SERIAL_DATA_OE_B), .UNDERRUN(UNDERRUN), .BUSY(BUSY)
);

//--- tb/asro_serial_out_tb.sv
`timescale 1ns/100ps

module asro_serial_out_tb;
    import asro_pkg::*;

    logic                clk        = 1'b0;
    logic                rst_b      = 1'b0;
    logic                valid      = 1'b0;
    logic [SEL_W-1:0]    sel        = 3'h0;
    logic [RESULT_W-1:0] data       = 12'h000;
    logic                sck;
    logic                trig;
    logic                ready;
    logic                dout;
    logic                oe_b;
    logic                under;
    logic                busy;
    int                  mismatches = 0;
    int                  tests_run  = 0;
    int                  n_under    = 0;
    logic [RESULT_W-1:0] exp_q [$];

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    asro_serial_out uut
    (
        .CLK(clk), .RST_B(rst_b), .SERIAL_CLOCK(sck), .CONVERSION_TRIGGER(trig),
        .CHANNEL_COUNT_SELECT_BIT0(sel[0]), .CHANNEL_COUNT_SELECT_BIT1(sel[1]),
        .CHANNEL_COUNT_SELECT_BIT2(sel[2]), .RESULT_DATA(data), .RESULT_VALID(valid),
        .RESULT_READY(ready), .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OE_B(oe_b),
        .UNDERRUN(under), .BUSY(busy)
    );

    asro_host host
    (
        .CLK(clk), .SDO(dout), .SDO_OE_B(oe_b), .SCK(sck), .FSYNC(trig)
    );

    always @(posedge clk)
    begin
        if (under === 1'b1)
            n_under <= n_under + 1;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_idle;
        chk(16'({oe_b, busy, ready, under}), 16'h000A);
        host.frame(20, 0, 1'b0);
        for (int r = 0; r < 20; r++)
            chk(16'(host.cap[r][1]), 16'h0001);
        $display("idle test done");
    endtask

    // Fill to the brim; the refused extra word must never reach the line
    task automatic t_fill;
        for (int i = 0; i < 32; i++)
        begin
            data  <= 12'hF00 ^ 12'(i * 183);
            valid <= 1'b1;
            exp_q.push_back(12'hF00 ^ 12'(i * 183));
            do
                @(posedge clk);
            while (ready !== 1'b1);
        end
        data <= 12'h5A5;
        repeat (3) @(posedge clk);
        chk(16'(ready), 16'h0000);
        valid <= 1'b0;
        $display("fill test done");
    endtask

    task automatic run_frame(input logic [SEL_W-1:0] code, input int retrig);
        int                  n;
        int                  u0;
        int                  empties;
        logic [1:0]          c;
        logic [1:0]          e;
        logic [RESULT_W-1:0] w [0:5];
        n       = (code == 3'h0 || code == 3'h7) ? 6 : int'(code);
        u0      = n_under;
        empties = 0;
        for (int s = 0; s < n; s++)
        begin
            empties += (exp_q.size() == 0);
            w[s] = (exp_q.size() == 0) ? RESULT_ZERO : exp_q.pop_front();
        end
        sel <= code;
        host.frame(98, retrig, 1'b1);
        for (int r = 0; r < 98; r++)
        begin
            c = host.cap[r];
            if (c[1])
                c[0] = 1'b0;
            if (r < 2 || (r - 2) / 16 >= n || (r - 2) % 16 >= 14)
                e = 2'h2;
            else if ((r - 2) % 16 >= 12)
                e = {1'b0, DONTCARE_LEVEL};
            else
                e = {1'b0, w[(r - 2) / 16][11 - (r - 2) % 16]};
            chk(16'(c), 16'(e));
        end
        chk(16'(n_under - u0), 16'(empties));
        chk(16'(busy), 16'h0000);
        $display("frame with code %0d done", code);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_idle;
        t_fill;
        for (int i = 1; i <= 7; i++)
            run_frame(3'(i), (i == 6) ? 40 : 0);
        run_frame(3'h0, 0);
        print_verdict;
    end

    initial
    begin
        #(20000 * CLK_PERIOD_NS);
        mismatches++;
        print_verdict;
    end
endmodule
